// [hw/ufi_core.sv]
// Purpose: host data path, 16-deep fifos, receive start check and interrupt status
// Assumes: bus strobes are one-cycle pulses; tick16 is a one-cycle 16x pulse
// Notes: line format fixed at 8n1; tx serialiser lives here as tx_shift_reg
//
// Operation
// - start bit rechecked at centre, else dropped
// - host write loads transmit byte if room
// - holding-empty flag set on last-byte transfer or tx flush
// - receive read returns oldest byte, pops it
// - mask register: four enables, upper bits zero
// - receive interrupt follows trigger level crossing
// - data ready set on store, cleared empty
// - polled status bits five and six reported, seven zero
// - mode 0 tx ready low while tx empty
// - mode 0 rx ready low while data held
// - mode 1 tx ready high full, low empty
// - mode 1 rx ready low trigger/timeout till empty
// - mode 1 interrupts at empty and trigger
// - trigger codes give 1, 4, 8, 14
// - tx flush empties fifo, self clears
// - rx flush empties fifo, self clears
// - control bits need enable bit in write
// - status read clears only top pending source
// - source codes encoded by priority
// - bit zero low while any enabled source pending
// - bits 7:6 show fifos enabled
// - enabled pending source drives interrupt pin
// - registers reachable only with divisor bit clear
module ufi_core
    import ufi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire ufi_pkg::ufi_bus_t bus,
    input wire logic divisor_access,
    input wire logic tick16,
    input wire logic rx_line,
    input wire logic line_status_event,
    input wire logic modem_status_event,
    output logic [7:0] rdata,
    output logic tx_line,
    output logic irq,
    output logic tx_xfer_ready_n,
    output logic rx_xfer_ready_n,
    output logic [7:0] line_state_reg
);
    import ufi_pkg::*;

    function automatic logic [4:0] trig_level(input logic [1:0] code);
        case (code)
            2'h0: trig_level = 5'h01;
            2'h1: trig_level = 5'h04;
            2'h2: trig_level = 5'h08;
            default: trig_level = 5'h0e;
        endcase
    endfunction

    function automatic logic [3:0] ptr_inc(input logic [3:0] p);
        ptr_inc = p + 4'h1;
    endfunction

    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [7:0] rx_mem [FIFO_DEPTH];
    logic [3:0] tx_rp_q, tx_wp_q, rx_rp_q, rx_wp_q;
    logic [4:0] tx_cnt_q, rx_cnt_q;
    logic [3:0] irq_mask_reg_q;
    ufi_qctl_t qctl_q;
    logic thre_pend_q, line_pend_q, modem_pend_q, timeout_q;
    logic [7:0] rdata_q, lsr_q;
    logic irq_q, txr_q, rxr_q;
    logic tx_line_q;
    logic [5:0] idle_bits_q;
    logic [3:0] idle_tick_q;

    // the normal register set hides while the divisor latch is open
    wire acc_ok = !divisor_access;
    wire wr_data = bus.wr && acc_ok && bus.addr == ADDR_DATA;
    wire rd_data = bus.rd && acc_ok && bus.addr == ADDR_DATA;
    wire wr_mask = bus.wr && acc_ok && bus.addr == ADDR_MASK;
    wire wr_qctl = bus.wr && acc_ok && bus.addr == ADDR_QCTL;
    wire rd_isrc = bus.rd && acc_ok && bus.addr == ADDR_QCTL;
    wire qctl_take = wr_qctl && bus.wdata[QC_EN];
    wire tx_flush = qctl_take && bus.wdata[QC_TXFLUSH];
    wire rx_flush = qctl_take && bus.wdata[QC_RXFLUSH];
    // without fifos the holding register acts as a one-deep queue
    wire [4:0] cap = qctl_q.en ? DEPTH_FULL : 5'h01;
    wire tx_full = tx_cnt_q >= cap;
    wire rx_full = rx_cnt_q >= cap;
    wire tx_empty = tx_cnt_q == 5'h00;
    wire rx_empty = rx_cnt_q == 5'h00;

    // transmit serialiser
    logic [9:0] tx_shift_reg_q;
    logic [3:0] tx_bits_q, tx_tick_q;
    wire tx_busy = tx_bits_q != 4'h0;
    wire tx_load = !tx_busy && !tx_empty && !tx_flush;
    wire tx_push = wr_data && !tx_full;
    wire tx_bit_end = tx_busy && tick16 && tx_tick_q == TICK_LAST;

    // receive deserialiser
    ufi_rx_state_t rx_st_q;
    logic [3:0] rx_tick_q, rx_bit_q;
    logic [7:0] rx_shift_reg_q;
    logic rx_line_q;
    wire rx_fall = rx_line_q && !rx_line;
    wire rx_mid = tick16 && rx_tick_q == START_MID;
    wire rx_sample = tick16 && rx_tick_q == TICK_LAST;
    wire rx_done = rx_st_q == RX_STOP && rx_sample;
    // a full fifo drops the new character; stored bytes stay intact
    wire rx_push = rx_done && rx_line && !rx_full && !rx_flush;
    wire rx_pop = rd_data && !rx_empty && !rx_flush;

    wire [4:0] trig = trig_level(qctl_q.trig);
    wire rx_trig = qctl_q.en ? (rx_cnt_q >= trig) : !rx_empty;
    wire rx_pend = rx_trig || timeout_q;
    wire [3:0] pend_code = (line_pend_q && irq_mask_reg_q[MASK_LINE]) ? ISRC_LINE :
        (timeout_q && irq_mask_reg_q[MASK_RX]) ? ISRC_TIMEOUT :
        (rx_trig && irq_mask_reg_q[MASK_RX]) ? ISRC_RXDATA :
        (thre_pend_q && irq_mask_reg_q[MASK_THRE]) ? ISRC_THRE :
        (modem_pend_q && irq_mask_reg_q[MASK_MODEM]) ? ISRC_MODEM : ISRC_NONE;
    wire [7:0] isrc_val = {{2{qctl_q.en}}, 2'h0, pend_code};
    wire [7:0] rd_mux = rd_data ? (rx_empty ? 8'h00 : rx_mem[rx_rp_q]) :
        (bus.addr == ADDR_MASK) ? {4'h0, irq_mask_reg_q} : isrc_val;
    wire tx_all_empty = tx_empty && !tx_busy;
    wire [7:0] lsr_val = {1'b0, tx_all_empty, tx_empty, 4'h0, !rx_empty};
    wire txr_d = qctl_q.mode1 && qctl_q.en ? (tx_full ? 1'b1 : tx_empty ? 1'b0 : txr_q)
        : !tx_empty;
    wire rxr_d = qctl_q.mode1 && qctl_q.en ?
        (rx_pend ? 1'b0 : rx_empty ? 1'b1 : rxr_q) : rx_empty;
    wire idle_char = tick16 && idle_tick_q == TICK_LAST && idle_bits_q == TIMEOUT_BITS;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_rp_q <= 4'h0;
            tx_wp_q <= 4'h0;
            tx_cnt_q <= 5'h00;
        end else if (tx_flush) begin
            tx_rp_q <= 4'h0;
            tx_wp_q <= 4'h0;
            tx_cnt_q <= 5'h00;
        end else begin
            if (tx_push) tx_wp_q <= ptr_inc(tx_wp_q);
            if (tx_load) tx_rp_q <= ptr_inc(tx_rp_q);
            tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_load};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (tx_push) tx_mem[tx_wp_q] <= bus.wdata;
        if (rx_push) rx_mem[rx_wp_q] <= rx_shift_reg_q;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_shift_reg_q <= 10'h3ff;
            tx_bits_q <= 4'h0;
            tx_tick_q <= 4'h0;
        end else if (tx_load) begin
            tx_shift_reg_q <= {1'b1, tx_mem[tx_rp_q], 1'b0};
            tx_bits_q <= BITS_PER_CHAR + 4'h1;
            tx_tick_q <= 4'h0;
        end else if (tx_busy && tick16) begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_bit_end) begin
                tx_shift_reg_q <= {1'b1, tx_shift_reg_q[9:1]};
                tx_bits_q <= tx_bits_q - 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_st_q <= RX_IDLE;
            rx_tick_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_shift_reg_q <= 8'h00;
            rx_line_q <= 1'b1;
        end else begin
            rx_line_q <= rx_line;
            if (tick16) rx_tick_q <= rx_tick_q + 4'h1;
            case (rx_st_q)
                RX_IDLE: if (rx_fall) begin
                    rx_st_q <= RX_START;
                    rx_tick_q <= 4'h0;
                end
                RX_START: if (rx_mid) begin
                    rx_st_q <= rx_line ? RX_IDLE : RX_DATA;
                    rx_tick_q <= 4'h0;
                    rx_bit_q <= 4'h0;
                end
                RX_DATA: if (rx_sample) begin
                    rx_shift_reg_q <= {rx_line, rx_shift_reg_q[7:1]};
                    rx_bit_q <= rx_bit_q + 4'h1;
                    if (rx_bit_q == 4'h7) rx_st_q <= RX_STOP;
                end
                RX_STOP: if (rx_sample) rx_st_q <= RX_IDLE;
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || rx_flush) begin
            rx_rp_q <= 4'h0;
            rx_wp_q <= 4'h0;
            rx_cnt_q <= 5'h00;
        end else begin
            if (rx_push) rx_wp_q <= ptr_inc(rx_wp_q);
            if (rx_pop) rx_rp_q <= ptr_inc(rx_rp_q);
            rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
        end
    end

    // timeout counts idle bit times; any push or pop restarts it
    always_ff @(posedge sys_clk) begin
        if (reset || rx_push || rx_pop || rx_empty || rx_trig) begin
            idle_bits_q <= 6'h00;
            idle_tick_q <= 4'h0;
            timeout_q <= 1'b0;
        end else if (qctl_q.en && tick16) begin
            idle_tick_q <= idle_tick_q + 4'h1;
            if (idle_tick_q == TICK_LAST && idle_bits_q != TIMEOUT_BITS)
                idle_bits_q <= idle_bits_q + 6'h01;
            if (idle_char) timeout_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_mask_reg_q <= MASK_RESET;
            qctl_q <= QCTL_RESET;
        end else begin
            if (wr_mask) irq_mask_reg_q <= bus.wdata[3:0];
            if (wr_qctl) begin
                qctl_q.en <= bus.wdata[QC_EN];
                if (qctl_take) begin
                    qctl_q.mode1 <= bus.wdata[QC_MODE];
                    qctl_q.trig <= bus.wdata[7:6];
                end
            end
        end
    end

    // set beats the read clear: a new event in the read cycle survives
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            thre_pend_q <= 1'b1;
            line_pend_q <= 1'b0;
            modem_pend_q <= 1'b0;
        end else begin
            // set when the last fifo byte moves to the shifter or on a tx flush
            if (tx_load && tx_cnt_q == 5'h01 || tx_flush) thre_pend_q <= 1'b1;
            else if (tx_push) thre_pend_q <= 1'b0;
            else if (rd_isrc && pend_code == ISRC_THRE) thre_pend_q <= 1'b0;
            if (line_status_event) line_pend_q <= 1'b1;
            else if (rd_isrc && pend_code == ISRC_LINE) line_pend_q <= 1'b0;
            if (modem_status_event) modem_pend_q <= 1'b1;
            else if (rd_isrc && pend_code == ISRC_MODEM) modem_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
            lsr_q <= 8'h60;
            irq_q <= 1'b0;
            txr_q <= 1'b0;
            rxr_q <= 1'b1;
            tx_line_q <= 1'b1;
        end else begin
            if (bus.rd && acc_ok) rdata_q <= rd_mux;
            lsr_q <= lsr_val;
            irq_q <= pend_code != ISRC_NONE;
            txr_q <= txr_d;
            rxr_q <= rxr_d;
            tx_line_q <= tx_busy ? tx_shift_reg_q[0] : 1'b1;
        end
    end

    assign rdata = rdata_q;
    assign tx_line = tx_line_q;
    assign irq = irq_q;
    assign tx_xfer_ready_n = txr_q;
    assign rx_xfer_ready_n = rxr_q;
    assign line_state_reg = lsr_q;
endmodule

// [hw/ufi_pkg.sv]
// Purpose: shared constants and types for the uart fifo and interrupt core
// Assumes: 40 MHz sys_clk, 16x sample tick supplied from the baud divider
// Notes: register addresses follow the three-bit parallel bus map
package ufi_pkg;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_MASK = 3'h1;
    localparam logic [2:0] ADDR_QCTL = 3'h2;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] DEPTH_FULL = 5'h10;
    localparam logic [3:0] START_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] BITS_PER_CHAR = 4'h9;
    localparam logic [5:0] TIMEOUT_BITS = 6'h28;
    localparam logic [3:0] ISRC_LINE = 4'h6;
    localparam logic [3:0] ISRC_RXDATA = 4'h4;
    localparam logic [3:0] ISRC_TIMEOUT = 4'hc;
    localparam logic [3:0] ISRC_THRE = 4'h2;
    localparam logic [3:0] ISRC_MODEM = 4'h0;
    localparam logic [3:0] ISRC_NONE = 4'h1;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam int MASK_RX = 0;
    localparam int MASK_THRE = 1;
    localparam int MASK_LINE = 2;
    localparam int MASK_MODEM = 3;
    localparam int QC_EN = 0;
    localparam int QC_RXFLUSH = 1;
    localparam int QC_TXFLUSH = 2;
    localparam int QC_MODE = 3;
    typedef struct packed {
        logic [1:0] trig;
        logic mode1;
        logic en;
    } ufi_qctl_t;
    localparam ufi_qctl_t QCTL_RESET = '{trig: 2'h0, mode1: 1'b0, en: 1'b0};
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ufi_bus_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufi_rx_state_t;
endpackage

// [testbench/tb.sv]
// Purpose: self-checking bench for the fifo and interrupt core
// Assumes: tick16 every cycle to keep characters short
// Notes: read results are queued and compared by a separate monitor
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ufi_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    ufi_bus_t bus = '0;
    logic divisor_access = 1'b0;
    logic line_ev = 1'b0, modem_ev = 1'b0, go = 1'b0, glitch = 1'b0, p1 = 1'b0, p2 = 1'b0;
    logic [7:0] data = 8'h00, d, rdata, line_state_reg;
    logic rx_line, tx_line, irq, tx_rdy_n, rx_rdy_n, busy;
    logic [7:0] exp_q[$], sent[$];
    int num_errors = 0, compares = 0, seed = 35827, lvl[4] = '{1, 4, 8, 14};
    ufi_core DUT (.sys_clk(sys_clk), .reset(reset), .bus(bus), .divisor_access(divisor_access),
        .tick16(1'b1), .rx_line(rx_line), .line_status_event(line_ev),
        .modem_status_event(modem_ev), .rdata(rdata), .tx_line(tx_line), .irq(irq),
        .tx_xfer_ready_n(tx_rdy_n), .rx_xfer_ready_n(rx_rdy_n), .line_state_reg(line_state_reg));
    ufi_line_model u_line (.sys_clk(sys_clk), .tick16(1'b1), .go(go), .glitch(glitch),
        .data(data), .rx_line(rx_line), .busy(busy));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s got %h", $time, what, got);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp, input string what);
        chk_byte({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        bus = '{1'b0, 1'b1, a, v};
        @(negedge sys_clk);
        bus = '0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(negedge sys_clk);
        bus = '{1'b1, 1'b0, a, 8'h00};
        @(negedge sys_clk);
        bus = '0;
        @(negedge sys_clk);
    endtask
    // bounded wait for the sender (tx=0) or the transmitter (tx=1) to go idle
    task automatic wait_idle(input bit tx);
        int n;
        n = 0;
        while ((tx ? !line_state_reg[6] : busy) && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 400) begin
            chk_pin(1'b0, 1'b1, "timeout");
            close_out();
        end
    endtask
    task automatic send(input logic [7:0] v, input logic g);
        @(negedge sys_clk);
        data = v;
        glitch = g;
        go = 1'b1;
        @(negedge sys_clk);
        go = 1'b0;
        wait_idle(1'b0);
        repeat (3) @(negedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        p1 <= bus.rd && !divisor_access;
        p2 <= p1;
    end
    always @(negedge sys_clk) if (p2) chk_byte(rdata, exp_q.pop_front(), "read");
    initial begin
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        chk_byte(line_state_reg, 8'h60, "status reset");
        chk_pin(tx_rdy_n, 1'b0, "tx ready reset");
        chk_pin(rx_rdy_n, 1'b1, "rx ready reset");
        chk_pin(tx_line, 1'b1, "tx idle reset");
        rd(ADDR_QCTL, 8'h01);
        rd(ADDR_MASK, 8'h00);
        divisor_access = 1'b1;
        wr(ADDR_MASK, 8'hff);
        divisor_access = 1'b0;
        rd(ADDR_MASK, 8'h00);
        wr(ADDR_MASK, 8'hff);
        rd(ADDR_MASK, 8'h0f);
        chk_pin(irq, 1'b1, "thre irq");
        rd(ADDR_QCTL, 8'h02);
        rd(ADDR_QCTL, 8'h01);
        line_ev = 1'b1;
        modem_ev = 1'b1;
        @(negedge sys_clk);
        line_ev = 1'b0;
        modem_ev = 1'b0;
        rd(ADDR_QCTL, 8'h06);
        rd(ADDR_QCTL, 8'h00);
        divisor_access = 1'b1;
        @(negedge sys_clk);
        bus = '{1'b1, 1'b0, ADDR_MASK, 8'h00};
        @(negedge sys_clk);
        bus = '0;
        divisor_access = 1'b0;
        @(negedge sys_clk);
        chk_byte(rdata, 8'h00, "divisor read");
        wr(ADDR_MASK, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_QCTL, {c[1:0], 6'h0b});
            for (int i = 0; i < lvl[c]; i++) begin
                chk_pin(rx_rdy_n, 1'b1, "below trigger");
                chk_pin(irq, 1'b0, "irq below trigger");
                d = $random(seed);
                sent.push_back(d);
                send(d, 1'b0);
            end
            chk_pin(rx_rdy_n, 1'b0, "at trigger");
            chk_pin(irq, 1'b1, "irq at trigger");
            rd(ADDR_QCTL, 8'hc4);
            foreach (sent[i]) begin
                rd(ADDR_DATA, sent[i]);
                chk_pin(irq, 1'b0, "irq after read");
                chk_pin(rx_rdy_n, i == lvl[c] - 1, "rx ready hold");
            end
            chk_pin(line_state_reg[0], 1'b0, "drained");
            sent.delete();
        end
        d = $random(seed);
        send(d, 1'b0);
        repeat (700) @(negedge sys_clk);
        chk_pin(rx_rdy_n, 1'b0, "timeout ready");
        chk_pin(irq, 1'b1, "timeout irq");
        rd(ADDR_QCTL, 8'hcc);
        rd(ADDR_DATA, d);
        wr(ADDR_QCTL, 8'h01);
        send(8'h00, 1'b1);
        chk_pin(line_state_reg[0], 1'b0, "false start");
        send(8'h5a, 1'b0);
        chk_pin(line_state_reg[0], 1'b1, "data ready");
        chk_pin(rx_rdy_n, 1'b0, "mode0 rx ready");
        wr(ADDR_QCTL, 8'h03);
        @(negedge sys_clk);
        chk_pin(rx_rdy_n, 1'b1, "rx flushed");
        wr(ADDR_QCTL, 8'h09);
        repeat (18) begin
            d = $random(seed);
            wr(ADDR_DATA, d);
        end
        chk_pin(tx_rdy_n, 1'b1, "tx full");
        wr(ADDR_QCTL, 8'h0d);
        @(negedge sys_clk);
        chk_pin(line_state_reg[5], 1'b1, "tx flushed");
        chk_pin(line_state_reg[6], 1'b0, "shifter kept");
        chk_pin(tx_rdy_n, 1'b0, "tx empty");
        wait_idle(1'b1);
        chk_pin(tx_line, 1'b1, "tx idle after drain");
        wr(ADDR_QCTL, 8'h08);
        rd(ADDR_QCTL, 8'h01);
        close_out();
    end
endmodule

// [testbench/ufi_core_asserts.sv]
// Purpose: port-level checks for the fifo and interrupt core
// Assumes: control and mask state are tracked from bus writes
// Notes: mode and mask rules wait one cycle after a change, since outputs are registered
module ufi_chk
    import ufi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire ufi_pkg::ufi_bus_t bus,
    input wire logic divisor_access,
    input wire logic [7:0] rdata,
    input wire logic irq,
    input wire logic tx_xfer_ready_n,
    input wire logic rx_xfer_ready_n,
    input wire logic [7:0] line_state_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    logic m1_q, m1p_q, mz_q, mzp_q;
    logic [3:0] pop_q;
    wire wr_ok = bus.wr && !divisor_access;
    wire qc_wr = wr_ok && bus.addr == ADDR_QCTL;
    wire pop = (bus.rd && !divisor_access && bus.addr == ADDR_DATA) || qc_wr;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            m1_q <= 1'b0;
            m1p_q <= 1'b0;
            mz_q <= 1'b1;
            mzp_q <= 1'b1;
            pop_q <= 4'h0;
        end else begin
            if (qc_wr) m1_q <= bus.wdata[QC_EN] & bus.wdata[QC_MODE];
            if (wr_ok && bus.addr == ADDR_MASK) mz_q <= bus.wdata[3:0] == 4'h0;
            m1p_q <= m1_q;
            mzp_q <= mz_q;
            pop_q <= {pop_q[2:0], pop};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_reset_state: assert property (disable iff (1'b0) reset |=>
        line_state_reg == 8'h60 && !irq && !tx_xfer_ready_n && rx_xfer_ready_n)
        else $error("outputs wrong after reset");
    a_rx_mode0: assert property (!m1_q && !m1p_q |-> rx_xfer_ready_n == !line_state_reg[0])
        else $error("rx ready differs from data ready");
    a_tx_mode0: assert property (!m1_q && !m1p_q |-> tx_xfer_ready_n == !line_state_reg[5])
        else $error("tx ready differs from tx empty");
    a_tx_mode1_empty: assert property (m1_q && m1p_q && line_state_reg[5] |-> !tx_xfer_ready_n)
        else $error("tx ready high with empty fifo");
    a_rx_mode1_hold: assert property (m1_q && m1p_q && $rose(rx_xfer_ready_n) |->
        !line_state_reg[0]) else $error("rx ready released with data held");
    a_all_empty: assert property (line_state_reg[6] |-> line_state_reg[5])
        else $error("all empty without fifo empty");
    a_write_busy: assert property (wr_ok && bus.addr == ADDR_DATA |-> ##[1:3] !line_state_reg[6])
        else $error("transmit write left transmitter empty");
    a_mask_quiet: assert property (mz_q && mzp_q |-> !irq)
        else $error("irq with all sources masked");
    a_ready_fall: assert property ($fell(line_state_reg[0]) |-> pop_q != 4'h0)
        else $error("data ready cleared without a read");
    a_div_read: assert property (bus.rd && divisor_access && !$past(bus.rd) |=> $stable(rdata))
        else $error("read taken while divisor open");
    c_irq: cover property ($rose(irq));
    c_tx_full: cover property (m1_q && tx_xfer_ready_n);
    c_rx_trig: cover property (m1_q && $fell(rx_xfer_ready_n));
endmodule

bind ufi_core ufi_chk u_chk (.sys_clk(sys_clk), .reset(reset), .bus(bus),
    .divisor_access(divisor_access), .rdata(rdata), .irq(irq),
    .tx_xfer_ready_n(tx_xfer_ready_n), .rx_xfer_ready_n(rx_xfer_ready_n),
    .line_state_reg(line_state_reg));

// [testbench/ufi_line_model.sv]
// Purpose: far-end serial sender feeding the receive line
// Assumes: 8n1 frames, 16 ticks per bit
// Notes: glitch mode gives a short low that must not start a character
module ufi_line_model (
    input wire logic sys_clk,
    input wire logic tick16,
    input wire logic go,
    input wire logic glitch,
    input wire logic [7:0] data,
    output logic rx_line,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] frame_q;
    logic [7:0] cnt_q;
    logic glitch_q;
    initial busy = 1'b0;
    always @(posedge sys_clk) begin
        if (!busy && go) begin
            frame_q <= {1'b1, data, 1'b0};
            glitch_q <= glitch;
            cnt_q <= 8'h00;
            busy <= 1'b1;
        end else if (busy && tick16) begin
            cnt_q <= cnt_q + 8'h01;
            busy <= cnt_q != 8'h9f;
        end
    end
    // line idles high between frames, as a real sender leaves it
    assign rx_line = !busy || (glitch_q ? cnt_q > 8'h03 : frame_q[cnt_q[7:4]]);
endmodule
